// [core/cos_pkg.sv]
package cos_pkg;
  // Register offsets (management bus command codes)
  localparam logic [7:0] ADDR_ON_OFF_CONFIGURATION = 8'h02;
  localparam logic [7:0] ADDR_OUTPUT_VOLTAGE_SETPOINT = 8'h21;
  localparam logic [7:0] ADDR_OVERCURRENT_FAULT_LIMIT = 8'h46;
  localparam logic [7:0] ADDR_OVERTEMP_FAULT_LIMIT = 8'h4f;
  localparam logic [7:0] ADDR_OVERTEMP_WARNING_LIMIT = 8'h51;
  localparam logic [7:0] ADDR_GOOD_ON_THRESHOLD = 8'h5e;
  localparam logic [7:0] ADDR_GOOD_OFF_THRESHOLD = 8'h5f;
  localparam logic [7:0] ADDR_TURN_ON_WAIT_TIME = 8'h60;
  localparam logic [7:0] ADDR_RISE_RAMP_TIME = 8'h61;
  localparam logic [7:0] ADDR_TURN_OFF_WAIT_TIME = 8'h64;
  localparam logic [7:0] ADDR_FALL_RAMP_TIME = 8'h65;
  localparam logic [7:0] ADDR_PREBIAS_SINK_TIME_LIMIT = 8'h66;
  localparam logic [7:0] ADDR_TEMPERATURE_READOUT = 8'h8d;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'h79;
  localparam logic [7:0] ADDR_GOOD_POLARITY_SELECT = 8'hd0;
  localparam logic [7:0] ADDR_BUS_ADDRESS_OFFSET = 8'hee;
  localparam logic [7:0] ADDR_HEADER_PIN_FUNCTION = 8'hf9;
  // Field positions and codes
  localparam int ONOFF_SOFT_STOP_BIT = 0;
  localparam int STATUS_GOOD_N_BIT = 11;
  localparam int STATUS_FAULT_BIT = 0;
  localparam logic [7:0] POL_ACTIVE_LOW = 8'h00;
  localparam logic [7:0] POL_ACTIVE_HIGH = 8'h01;
  localparam logic [7:0] PIN_PUSH_PULL = 8'h04;
  localparam logic [7:0] PIN_OPEN_DRAIN = 8'h06;
  // Reset values, voltages in millivolt units, times in ms
  localparam logic [15:0] RST_SETPOINT = 16'h2f44;   // 12100 mV
  localparam logic [15:0] RST_VOUT_MAX = 16'h36b0;   // 14000 mV
  localparam logic [15:0] RST_VOUT_MIN = 16'h1f40;   // 8000 mV
  localparam logic [15:0] RST_GOOD_ON = 16'h1f40;    // 8 V
  localparam logic [15:0] RST_GOOD_OFF = 16'h1388;   // 5 V
  localparam logic [15:0] RST_RISE_MS = 16'h000a;    // 10 ms
  localparam logic [15:0] RST_TON_MS = 16'h0000;
  localparam logic [15:0] RST_TON_PARALLEL_MS = 16'h00c8; // 200 ms
  localparam logic [15:0] RST_TOFF_MS = 16'h0000;
  localparam logic [15:0] RST_FALL_MS = 16'h000a;
  localparam logic [15:0] RST_SINK_MS = 16'h000a;
  localparam logic [15:0] RST_OC_LIMIT = 16'h00c8;
  localparam logic [15:0] RST_OT_FAULT = 16'h007d;
  localparam logic [15:0] RST_OT_WARN = 16'h0073;
  localparam logic [7:0] RST_ON_OFF = 8'h00;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_PIN_FUNC = 8'h04;
  localparam logic [7:0] RST_ADDR_OFFSET = 8'h00;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int MS_CYCLES = 1000 * CLK_MHZ;
  localparam int BOOT_MS = 30;
  localparam int BOOT_CYCLES = BOOT_MS * MS_CYCLES;
  localparam int VIN_RESPONSE_US = 100;
  localparam int VIN_RESPONSE_CYCLES = VIN_RESPONSE_US * CLK_MHZ;
  localparam int MARGIN_PCT = 10;
  localparam int OVP_PCT = 17;
  localparam int PCT_SHIFT = 7;   // margin/ovp fractions in 1/128 units
  localparam logic [15:0] MARGIN_FRAC = 16'h000d;  // 13/128 ~ 10%
  localparam logic [15:0] OVP_FRAC = 16'h0016;     // 22/128 ~ 17%
  localparam logic [15:0] GOOD_TOL = 16'h0064;     // 100 mV window
  localparam logic [15:0] SHARE_STEP = 16'h0001;
  typedef enum logic [2:0] {
    ST_OFF, ST_TON_WAIT, ST_RISE, ST_REGULATE, ST_TOFF_WAIT, ST_FALL, ST_FAULT_WAIT
  } cos_state_t;
endpackage : cos_pkg

// [core/cos_sequencer.sv]
// Function
// R01 - Margin shifts setpoint ten percent up/down
// R02 - Changed setpoint clamps margin levels to limits
// R03 - Default rise ramp takes 10 ms
// R04 - Power-up start adds 30 ms boot
// R05 - Turn-on delay precedes rise ramp
// R06 - Turn-off delay precedes fall ramp
// R07 - Parallel units use 200 ms turn-on delay
// R08 - No start while start-critical fault present
// R09 - Soft-stop off by default, fall configurable
// R10 - Pre-bias below target: no sink, ramp up
// R11 - Pre-bias above target: sink limited time
// R12 - Load balance trims toward shared current
// R13 - Load balance inactive until regulating
// R14 - Overtemp retries; no start above warning
// R15 - Every start waits temperature below warning
// R16 - Input voltage faults answered within 100 us
// R17 - Output overvolt 17% above, auto re-enable
// R18 - Overcurrent shuts down, restarts automatically
// R19 - Good output inactive in ramp, thresholds
// R20 - Polarity select: 00 low, 01 high
// R21 - Pin function selects push-pull or open drain
// R22 - Status good flag: in tolerance, no fault
// R23 - Host pulls enable active to turn on
// R24 - Sequencer state machine with seven states
`timescale 1ns/1ps
`default_nettype none
module cos_sequencer
  import cos_pkg::*;
#(
  parameter int BOOT_CYC = BOOT_CYCLES,
  parameter int MS_CYC = MS_CYCLES,
  parameter int VIN_RESP_CYC = VIN_RESPONSE_CYCLES,
  parameter bit PARALLEL_UNIT = 1'b0
) (
  input wire logic clk, // 100 MHz
  input wire logic rst_n, // Sync reset, low active
  input wire logic input_power_applied, // Reset came from input power-up
  input wire logic primary_enable_input, // High = on (already decoded)
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Command code
  input wire logic [15:0] reg_wdata, // Write data
  output logic [15:0] reg_rdata, // Read data
  output logic reg_rvalid, // Read data valid pulse
  input wire logic margin_high, // Margin up request
  input wire logic margin_low, // Margin down request
  input wire logic active_load_balance, // Active share mode
  input wire logic [15:0] vout_meas, // Measured output
  input wire logic [15:0] iout_meas, // Measured output current
  input wire logic [15:0] share_bus_current, // Shared bus current
  input wire logic [15:0] temperature, // Temperature readout
  input wire logic vin_over, // Input overvoltage level
  input wire logic vin_under, // Input undervoltage level
  output logic [15:0] vout_target, // Setpoint to regulator
  output logic regulate_en, // Regulation running
  output logic sink_allowed, // Sync rectifier may sink
  output logic output_good_out, // Good pin level
  output logic output_good_oe, // Good pin drive enable
  output logic fault_active // Any fault latched
);
  cos_state_t state, next_state;
  logic [7:0] on_off_configuration, good_polarity_select, header_pin_function;
  logic [7:0] bus_address_offset;
  logic [15:0] output_voltage_setpoint, overcurrent_fault_limit, overtemp_fault_limit;
  logic [15:0] overtemp_warning_limit, good_on_threshold, good_off_threshold;
  logic [15:0] turn_on_wait_time, rise_ramp_time, turn_off_wait_time, fall_ramp_time;
  logic [15:0] prebias_sink_time_limit;
  logic setpoint_changed;
  logic [31:0] timer, boot_cnt, vin_cnt, sink_cnt;
  logic [31:0] ms_cnt;
  logic [15:0] ms_elapsed;
  logic boot_done, vin_fault, ovp_fault, ocp_fault, ot_fault, good_int;
  logic [15:0] ramp_v, trim;
  logic [15:0] margin_target, ovp_level;
  logic start_ok, any_fault, in_tol;

  function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [15:0] frac);
    logic [31:0] p;
    p = 32'(v) * 32'(frac);
    return p[PCT_SHIFT +: 16];
  endfunction : pct_of

  // Register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      on_off_configuration <= RST_ON_OFF; // [R09]
      output_voltage_setpoint <= RST_SETPOINT;
      overcurrent_fault_limit <= RST_OC_LIMIT;
      overtemp_fault_limit <= RST_OT_FAULT;
      overtemp_warning_limit <= RST_OT_WARN;
      good_on_threshold <= RST_GOOD_ON; // [R19]
      good_off_threshold <= RST_GOOD_OFF; // [R19]
      turn_on_wait_time <= PARALLEL_UNIT ? RST_TON_PARALLEL_MS : RST_TON_MS; // [R07]
      rise_ramp_time <= RST_RISE_MS; // [R03]
      turn_off_wait_time <= RST_TOFF_MS;
      fall_ramp_time <= RST_FALL_MS;
      prebias_sink_time_limit <= RST_SINK_MS;
      good_polarity_select <= RST_POLARITY; // [R20]
      header_pin_function <= PARALLEL_UNIT ? PIN_OPEN_DRAIN : RST_PIN_FUNC; // [R21]
      bus_address_offset <= RST_ADDR_OFFSET;
      setpoint_changed <= 1'b0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_ON_OFF_CONFIGURATION: on_off_configuration <= reg_wdata[7:0];
        ADDR_OUTPUT_VOLTAGE_SETPOINT: begin
          output_voltage_setpoint <= reg_wdata;
          setpoint_changed <= 1'b1;
        end
        ADDR_OVERCURRENT_FAULT_LIMIT: overcurrent_fault_limit <= reg_wdata;
        ADDR_OVERTEMP_FAULT_LIMIT: overtemp_fault_limit <= reg_wdata;
        ADDR_OVERTEMP_WARNING_LIMIT: overtemp_warning_limit <= reg_wdata;
        ADDR_GOOD_ON_THRESHOLD: good_on_threshold <= reg_wdata;
        ADDR_GOOD_OFF_THRESHOLD: good_off_threshold <= reg_wdata;
        ADDR_TURN_ON_WAIT_TIME: turn_on_wait_time <= reg_wdata;
        ADDR_RISE_RAMP_TIME: rise_ramp_time <= reg_wdata;
        ADDR_TURN_OFF_WAIT_TIME: turn_off_wait_time <= reg_wdata;
        ADDR_FALL_RAMP_TIME: fall_ramp_time <= reg_wdata;
        ADDR_PREBIAS_SINK_TIME_LIMIT: prebias_sink_time_limit <= reg_wdata;
        ADDR_GOOD_POLARITY_SELECT: good_polarity_select <= reg_wdata[7:0];
        ADDR_BUS_ADDRESS_OFFSET: bus_address_offset <= reg_wdata[7:0];
        ADDR_HEADER_PIN_FUNCTION: header_pin_function <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Register reads, one cycle latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_ON_OFF_CONFIGURATION: reg_rdata <= {8'h00, on_off_configuration};
          ADDR_OUTPUT_VOLTAGE_SETPOINT: reg_rdata <= output_voltage_setpoint;
          ADDR_OVERCURRENT_FAULT_LIMIT: reg_rdata <= overcurrent_fault_limit;
          ADDR_OVERTEMP_FAULT_LIMIT: reg_rdata <= overtemp_fault_limit;
          ADDR_OVERTEMP_WARNING_LIMIT: reg_rdata <= overtemp_warning_limit;
          ADDR_GOOD_ON_THRESHOLD: reg_rdata <= good_on_threshold;
          ADDR_GOOD_OFF_THRESHOLD: reg_rdata <= good_off_threshold;
          ADDR_TURN_ON_WAIT_TIME: reg_rdata <= turn_on_wait_time;
          ADDR_RISE_RAMP_TIME: reg_rdata <= rise_ramp_time;
          ADDR_TURN_OFF_WAIT_TIME: reg_rdata <= turn_off_wait_time;
          ADDR_FALL_RAMP_TIME: reg_rdata <= fall_ramp_time;
          ADDR_PREBIAS_SINK_TIME_LIMIT: reg_rdata <= prebias_sink_time_limit;
          ADDR_TEMPERATURE_READOUT: reg_rdata <= temperature;
          ADDR_STATUS_WORD: begin
            reg_rdata <= 16'h0000;
            reg_rdata[STATUS_GOOD_N_BIT] <= ~(good_int && in_tol); // [R22]
            reg_rdata[STATUS_FAULT_BIT] <= any_fault;
          end
          ADDR_GOOD_POLARITY_SELECT: reg_rdata <= {8'h00, good_polarity_select};
          ADDR_BUS_ADDRESS_OFFSET: reg_rdata <= {8'h00, bus_address_offset};
          ADDR_HEADER_PIN_FUNCTION: reg_rdata <= {8'h00, header_pin_function};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Boot interval after input power-up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_cnt <= 32'h0;
      boot_done <= 1'b0;
    end else if (!boot_done) begin
      if (!input_power_applied || boot_cnt >= 32'(BOOT_CYC - 1)) begin
        boot_done <= 1'b1; // [R04]
      end else begin
        boot_cnt <= boot_cnt + 32'h1;
      end
    end
  end

  // Input voltage fault qualified within response time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vin_cnt <= 32'h0;
      vin_fault <= 1'b0;
    end else if (vin_over || vin_under) begin
      if (vin_cnt >= 32'(VIN_RESP_CYC - 1)) begin
        vin_fault <= 1'b1; // [R16]
      end else begin
        vin_cnt <= vin_cnt + 32'h1;
        vin_fault <= vin_fault;
      end
    end else begin
      vin_cnt <= 32'h0;
      vin_fault <= 1'b0;
    end
  end

  // Protection levels; overvolt and overcurrent clear when the condition goes away, overtemp only below the warning limit
  always_comb begin
    ovp_level = output_voltage_setpoint + pct_of(output_voltage_setpoint, OVP_FRAC); // [R17]
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovp_fault <= 1'b0;
      ocp_fault <= 1'b0;
      ot_fault <= 1'b0;
    end else begin
      ovp_fault <= vout_meas > ovp_level; // [R17]
      ocp_fault <= iout_meas > overcurrent_fault_limit; // [R18]
      if (temperature >= overtemp_fault_limit) begin
        ot_fault <= 1'b1;
      end else if (temperature < overtemp_warning_limit) begin
        ot_fault <= 1'b0; // [R14]
      end
    end
  end
  always_comb begin
    any_fault = vin_fault || ovp_fault || ocp_fault || ot_fault;
    start_ok = boot_done && !any_fault && !vin_over && !vin_under
      && temperature < overtemp_warning_limit; // [R08] [R14] [R15]
    in_tol = (vout_meas > vout_target ? vout_meas - vout_target
      : vout_target - vout_meas) <= GOOD_TOL; // [R22]
  end

  // Margin target with clamping
  always_comb begin
    margin_target = output_voltage_setpoint;
    if (margin_high) begin
      margin_target = output_voltage_setpoint + pct_of(output_voltage_setpoint, MARGIN_FRAC); // [R01]
      if (setpoint_changed && margin_target > RST_VOUT_MAX) begin
        margin_target = RST_VOUT_MAX; // [R02]
      end
    end else if (margin_low) begin
      margin_target = output_voltage_setpoint - pct_of(output_voltage_setpoint, MARGIN_FRAC); // [R01]
      if (setpoint_changed && margin_target < RST_VOUT_MIN) begin
        margin_target = RST_VOUT_MIN; // [R02]
      end
    end
  end

  // Millisecond tick and state timer
  always_ff @(posedge clk) begin
    if (!rst_n || state != next_state) begin
      ms_cnt <= 32'h0;
      ms_elapsed <= 16'h0;
    end else if (ms_cnt >= 32'(MS_CYC - 1)) begin
      ms_cnt <= 32'h0;
      ms_elapsed <= ms_elapsed + 16'h1;
    end else begin
      ms_cnt <= ms_cnt + 32'h1;
    end
  end
  always_comb begin
    timer = 32'(ms_elapsed);
  end

  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF: if (primary_enable_input && start_ok) next_state = ST_TON_WAIT; // [R23]
      ST_TON_WAIT: begin
        if (any_fault) next_state = ST_FAULT_WAIT;
        else if (!primary_enable_input) next_state = ST_OFF;
        else if (timer >= 32'(turn_on_wait_time)) next_state = ST_RISE; // [R05]
      end
      ST_RISE: begin
        if (any_fault) next_state = ST_FAULT_WAIT;
        else if (!primary_enable_input) next_state = ST_TOFF_WAIT;
        else if (ramp_v == margin_target) next_state = ST_REGULATE;
      end
      ST_REGULATE: begin
        if (any_fault) next_state = ST_FAULT_WAIT; // [R17] [R18]
        else if (!primary_enable_input) next_state = ST_TOFF_WAIT;
      end
      ST_TOFF_WAIT: begin
        if (any_fault) next_state = ST_FAULT_WAIT;
        else if (timer >= 32'(turn_off_wait_time)) begin // [R06]
          next_state = on_off_configuration[ONOFF_SOFT_STOP_BIT] ? ST_FALL : ST_OFF; // [R09]
        end
      end
      ST_FALL: begin
        if (any_fault) next_state = ST_FAULT_WAIT;
        else if (ramp_v == 16'h0000) next_state = ST_OFF;
      end
      ST_FAULT_WAIT: if (start_ok) next_state = ST_OFF; // [R14] [R15]
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) state <= ST_OFF;
    else state <= next_state; // [R24]
  end

  // Ramp generator: one step per ms, size from target and ramp time
  always_ff @(posedge clk) begin
    logic [15:0] step;
    step = (rise_ramp_time == 16'h0) ? margin_target : margin_target / rise_ramp_time; // [R03]
    if (step == 16'h0) step = 16'h1;
    if (!rst_n) begin
      ramp_v <= 16'h0;
      sink_cnt <= 32'h0;
      sink_allowed <= 1'b0;
    end else begin
      if (state == ST_TON_WAIT) begin
        ramp_v <= vout_meas; // [R10]
        sink_cnt <= 32'h0;
        sink_allowed <= 1'b0;
      end else if (state == ST_RISE) begin
        if (ramp_v > margin_target) begin
          sink_cnt <= sink_cnt + 32'h1;
          sink_allowed <= sink_cnt < 32'(prebias_sink_time_limit) * 32'(MS_CYC); // [R11]
        end else begin
          sink_allowed <= 1'b0; // [R10]
        end
        if (ms_cnt == 32'h0 && ms_elapsed != 16'h0) begin
          if (ramp_v < margin_target) begin
            ramp_v <= (margin_target - ramp_v > step) ? ramp_v + step : margin_target;
          end else if (ramp_v > margin_target) begin
            ramp_v <= (ramp_v - margin_target > step) ? ramp_v - step : margin_target; // [R11]
          end
        end
      end else if (state == ST_REGULATE) begin
        ramp_v <= margin_target;
        sink_allowed <= 1'b1;
      end else if (state == ST_FALL) begin
        sink_allowed <= 1'b1;
        if (ms_cnt == 32'h0 && ms_elapsed != 16'h0) begin
          ramp_v <= (ramp_v > fall_ramp_step(ramp_v, fall_ramp_time)) ?
            ramp_v - fall_ramp_step(ramp_v, fall_ramp_time) : 16'h0; // [R09]
        end
      end else if (state != ST_TOFF_WAIT) begin
        ramp_v <= 16'h0;
        sink_allowed <= 1'b0;
      end
    end
  end

  function automatic logic [15:0] fall_ramp_step(input logic [15:0] v, input logic [15:0] t);
    logic [15:0] s;
    s = (t == 16'h0) ? v : output_voltage_setpoint / t;
    return (s == 16'h0) ? 16'h1 : s;
  endfunction : fall_ramp_step

  // Load balance trim only while regulating
  always_ff @(posedge clk) begin
    if (!rst_n || state != ST_REGULATE || !active_load_balance) begin
      trim <= 16'h0; // [R13]
    end else if (ms_cnt == 32'h0) begin
      if (iout_meas < share_bus_current) trim <= trim + SHARE_STEP; // [R12]
      else if (iout_meas > share_bus_current) trim <= trim - SHARE_STEP; // [R12]
    end
  end

  // Outputs and good indication
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      good_int <= 1'b0;
      vout_target <= 16'h0;
      regulate_en <= 1'b0;
      fault_active <= 1'b0;
      output_good_out <= 1'b0;
      output_good_oe <= 1'b1;
    end else begin
      if (state != ST_REGULATE || any_fault) good_int <= 1'b0; // [R19]
      else if (vout_meas > good_on_threshold) good_int <= 1'b1; // [R19]
      else if (vout_meas < good_off_threshold) good_int <= 1'b0; // [R19]
      vout_target <= ramp_v + trim;
      regulate_en <= state == ST_RISE || state == ST_REGULATE
        || state == ST_TOFF_WAIT || state == ST_FALL;
      fault_active <= any_fault;
      if (header_pin_function == PIN_OPEN_DRAIN) begin // [R21]
        output_good_out <= 1'b0;
        output_good_oe <= (good_polarity_select == POL_ACTIVE_HIGH) ? !good_int : good_int; // [R20]
      end else begin
        output_good_out <= (good_polarity_select == POL_ACTIVE_HIGH) ? good_int : !good_int; // [R20]
        output_good_oe <= 1'b1;
      end
    end
  end
endmodule : cos_sequencer
`default_nettype wire

// [tb/cos_plant_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cos_plant_model
  import cos_pkg::*;
(
  input wire logic en_req, // Bench on request
  input wire logic regulate_en, // Regulating
  input wire logic [15:0] vout_target, // Setpoint
  input wire logic [15:0] pre_level, // Idle output level
  input wire logic [15:0] bump, // Output error
  output logic primary_enable_input, // Decoded enable
  output logic [15:0] vout_meas // Sensed output
);
  // Enable pulled active while the bench asks for output
  assign primary_enable_input = en_req;
  // Output follows the target only while regulating
  assign vout_meas = (regulate_en === 1'b1) ? vout_target + bump : pre_level;
endmodule : cos_plant_model
`default_nettype wire

// [tb/cos_sequencer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module cos_sequencer_assertions
  import cos_pkg::*;
#(
  parameter int BOOT_CYC = BOOT_CYCLES,
  parameter int VIN_RESP_CYC = VIN_RESPONSE_CYCLES
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic input_power_applied, // Power-up start
  input wire logic primary_enable_input, // Enable
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read valid
  input wire logic [15:0] temperature, // Temperature
  input wire logic vin_over, // Input high
  input wire logic vin_under, // Input low
  input wire logic regulate_en, // Regulating
  input wire logic sink_allowed, // Sink permit
  input wire logic fault_active // Fault
);
  localparam int VIN_LIM = VIN_RESP_CYC + 4;
  int up_cnt;
  // Cycles since reset release, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_cnt <= 0;
    end else if (up_cnt < BOOT_CYC) begin
      up_cnt <= up_cnt + 1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence start_s;
    $rose(regulate_en);
  endsequence
  sequence vin_hit_s;
    $rose(vin_over || vin_under);
  endsequence
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved");
  vin_response_a: assert property (
    vin_hit_s |-> ##[1:VIN_LIM] (fault_active || !(vin_over || vin_under)))
    else $error("input fault too slow");
  fault_stop_a: assert property (fault_active |-> ##[0:2] !regulate_en)
    else $error("fault left regulation on");
  off_stays_a: assert property (
    (!primary_enable_input && !regulate_en) |=> !regulate_en)
    else $error("start without enable");
  temp_gate_a: assert property (start_s |-> temperature < RST_OT_WARN)
    else $error("start while hot");
  vin_gate_a: assert property (start_s |-> !(vin_over || vin_under))
    else $error("start during input fault");
  sink_scope_a: assert property (!regulate_en [*2] |-> !sink_allowed)
    else $error("sink while idle");
  boot_wait_a: assert property (start_s ##0 input_power_applied |-> up_cnt >= BOOT_CYC)
    else $error("boot wait skipped");
endmodule : cos_sequencer_assertions
`default_nettype wire

// [tb/test_converter_output_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("unexpected at %0t ns: got %h want %h", $time, (g), (e)); \
  end \
end
module test_converter_output_sequencer
  import cos_pkg::*;
;
  localparam int MS = 20;
  localparam int BOOT = 50;
  localparam int VRC = 10;
  logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b1, en_req = 1'b0, wr = 1'b0, rd = 1'b0;
  logic mh = 1'b0, ml = 1'b0, alb = 1'b0, vov = 1'b0, vun = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, iout = 16'h0064, share = 16'h0064, temp = 16'h0020;
  logic [15:0] pre = 16'h0000, bump = 16'h0000, v, rdata, vout_meas, vout_target;
  logic enable, rvalid, reg_on, sink, good_out, good_oe, fault;
  int bad_count = 0, n_tests = 0, t;
  logic [7:0] ra [8] = '{ADDR_ON_OFF_CONFIGURATION, ADDR_GOOD_ON_THRESHOLD,
    ADDR_GOOD_OFF_THRESHOLD, ADDR_RISE_RAMP_TIME, ADDR_TURN_ON_WAIT_TIME,
    ADDR_GOOD_POLARITY_SELECT, ADDR_HEADER_PIN_FUNCTION, 8'h03};
  logic [15:0] rv [8] = '{16'h0000, 16'h1f40, 16'h1388, 16'h000a, 16'h0000, 16'h0000,
    16'h0004, 16'h0000};
  always #5 clk = ~clk;
  cos_plant_model plant (.en_req(en_req), .regulate_en(reg_on), .vout_target(vout_target),
    .pre_level(pre), .bump(bump), .primary_enable_input(enable), .vout_meas(vout_meas));
  cos_sequencer #(.BOOT_CYC(BOOT), .MS_CYC(MS), .VIN_RESP_CYC(VRC), .PARALLEL_UNIT(1'b0)) uut (
    .clk(clk), .rst_n(rst_n), .input_power_applied(pwr), .primary_enable_input(enable),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .margin_high(mh), .margin_low(ml), .active_load_balance(alb),
    .vout_meas(vout_meas), .iout_meas(iout), .share_bus_current(share), .temperature(temp),
    .vin_over(vov), .vin_under(vun), .vout_target(vout_target), .regulate_en(reg_on),
    .sink_allowed(sink), .output_good_out(good_out), .output_good_oe(good_oe),
    .fault_active(fault));
  function automatic logic [15:0] mrg(input int sp, input int s);
    return 16'(sp + s * ((sp * int'(MARGIN_FRAC)) >>> PCT_SHIFT));
  endfunction : mrg
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    `CHK(rvalid, 1'b1)
    d = rdata;
    @(negedge clk);
  endtask : rd_reg
  task automatic wait_on(input logic lvl, input int lim);
    t = 0;
    while (reg_on !== lvl && t < lim) begin
      @(negedge clk);
      t++;
    end
    `CHK(reg_on, lvl)
  endtask : wait_on
  task automatic ms(input int n);
    repeat (n * MS) @(negedge clk);
  endtask : ms
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    en_req = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(ra[i], v);
      `CHK(v, rv[i])
    end
    `CHK(reg_on, 1'b0)
    wait_on(1'b1, 200);
    pwr = 1'b0;
    ms(5);
    `CHK(good_out, 1'b1)
    `CHK(vout_target < RST_SETPOINT, 1'b1)
    ms(6);
    `CHK(vout_target, RST_SETPOINT)
    `CHK(good_out, 1'b0)
    rd_reg(ADDR_STATUS_WORD, v);
    `CHK(v[STATUS_GOOD_N_BIT], 1'b0)
    $display("start and ramp done");
    mh = 1'b1;
    ms(2);
    `CHK(vout_target, mrg(12100, 1))
    mh = 1'b0;
    wr_reg(ADDR_OUTPUT_VOLTAGE_SETPOINT, 16'h34bc);
    mh = 1'b1;
    ms(2);
    `CHK(vout_target, RST_VOUT_MAX)
    mh = 1'b0;
    ml = 1'b1;
    ms(2);
    `CHK(vout_target, mrg(13500, -1))
    ml = 1'b0;
    wr_reg(ADDR_OUTPUT_VOLTAGE_SETPOINT, RST_SETPOINT);
    ms(2);
    share = 16'h0080;
    alb = 1'b1;
    ms(2);
    `CHK(vout_target > RST_SETPOINT, 1'b1)
    alb = 1'b0;
    share = iout;
    $display("margin and sharing done");
    iout = 16'h00c9;
    wait_on(1'b0, 20);
    rd_reg(ADDR_STATUS_WORD, v);
    `CHK(v[STATUS_FAULT_BIT], 1'b1)
    `CHK(good_out, 1'b1)
    iout = 16'h0064;
    wait_on(1'b1, 100);
    ms(11);
    temp = 16'h007d;
    wait_on(1'b0, 20);
    temp = 16'h0078;
    ms(3);
    `CHK(reg_on, 1'b0)
    temp = 16'h0020;
    wait_on(1'b1, 100);
    ms(11);
    bump = 16'h0900;
    wait_on(1'b0, 20);
    bump = 16'h0000;
    wait_on(1'b1, 100);
    ms(11);
    vun = 1'b1;
    wait_on(1'b0, VRC + 10);
    vun = 1'b0;
    wait_on(1'b1, 100);
    ms(11);
    $display("fault responses done");
    wr_reg(ADDR_TURN_OFF_WAIT_TIME, 16'h0001);
    en_req = 1'b0;
    repeat (10) @(negedge clk);
    `CHK(reg_on, 1'b1)
    wait_on(1'b0, 2 * MS);
    wr_reg(ADDR_TURN_OFF_WAIT_TIME, 16'h0000);
    wr_reg(ADDR_TURN_ON_WAIT_TIME, 16'h0002);
    en_req = 1'b1;
    repeat (30) @(negedge clk);
    `CHK(reg_on, 1'b0)
    wait_on(1'b1, 2 * MS);
    ms(11);
    wr_reg(ADDR_ON_OFF_CONFIGURATION, 16'h0001);
    wr_reg(ADDR_FALL_RAMP_TIME, 16'h0002);
    en_req = 1'b0;
    ms(2);
    `CHK(reg_on, 1'b1)
    `CHK(vout_target < RST_SETPOINT, 1'b1)
    wait_on(1'b0, 3 * MS);
    wr_reg(ADDR_ON_OFF_CONFIGURATION, 16'h0000);
    $display("delays and soft stop done");
    pre = 16'h1000;
    en_req = 1'b1;
    wait_on(1'b1, 3 * MS);
    ms(1);
    `CHK(sink, 1'b0)
    `CHK(vout_target >= 16'h1000, 1'b1)
    en_req = 1'b0;
    wait_on(1'b0, MS);
    pre = 16'h3200;
    en_req = 1'b1;
    wait_on(1'b1, 3 * MS);
    ms(1);
    `CHK(sink, 1'b1)
    ms(11);
    wr_reg(ADDR_GOOD_POLARITY_SELECT, {8'h00, POL_ACTIVE_HIGH});
    `CHK(good_out, 1'b1)
    wr_reg(ADDR_GOOD_POLARITY_SELECT, {8'h00, POL_ACTIVE_LOW});
    wr_reg(ADDR_HEADER_PIN_FUNCTION, {8'h00, PIN_OPEN_DRAIN});
    `CHK(good_out, 1'b0)
    `CHK(good_oe, 1'b1)
    en_req = 1'b0;
    wait_on(1'b0, MS);
    ms(1);
    `CHK(good_oe, 1'b0)
    $display("pre-bias and good pin done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("unexpected at %0t ns: run timed out", $time);
    stop_test();
  end
endmodule : test_converter_output_sequencer
bind cos_sequencer cos_sequencer_assertions #(.BOOT_CYC(BOOT_CYC),
  .VIN_RESP_CYC(VIN_RESP_CYC)) chk (.clk(clk), .rst_n(rst_n),
  .input_power_applied(input_power_applied), .primary_enable_input(primary_enable_input),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .temperature(temperature),
  .vin_over(vin_over), .vin_under(vin_under), .regulate_en(regulate_en),
  .sink_allowed(sink_allowed), .fault_active(fault_active));
`default_nettype wire
